// ===== hdl/mag_link.sv
// Brings the bus pins into the core clock and finds bus conditions.
module mag_link
  import mag_pkg::*;
(
  input  wire logic              clk,    // Core clock.
  input  wire logic              rst_b,  // Asynchronous reset, low.
  input  wire logic              scl_i,  // Bus clock pin level.
  input  wire logic              sda_i,  // Bus data pin level.
  output mag_bus_event_type      ev      // Conditions, one cycle each, plus the data level.
);

  logic [1:0] scl_sync_q;
  logic [1:0] scl_sync_d;
  logic [1:0] sda_sync_q;
  logic [1:0] sda_sync_d;
  logic       scl_last_q;
  logic       scl_last_d;
  logic       sda_last_q;
  logic       sda_last_d;

  always_comb
  begin
    scl_sync_d = {scl_sync_q[0], scl_i};
    sda_sync_d = {sda_sync_q[0], sda_i};
    scl_last_d = scl_sync_q[1];
    sda_last_d = sda_sync_q[1];
  end

  // Idle bus is pulled high, so the stages reset to one.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_last_q <= 1'b1;
      sda_last_q <= 1'b1;
    end
    else
    begin
      scl_sync_q <= scl_sync_d;
      sda_sync_q <= sda_sync_d;
      scl_last_q <= scl_last_d;
      sda_last_q <= sda_last_d;
    end
  end

  // A data change with the clock held high marks start or stop.
  always_comb
  begin
    ev.start = scl_last_q && scl_sync_q[1] && sda_last_q && !sda_sync_q[1];
    ev.stop  = scl_last_q && scl_sync_q[1] && !sda_last_q && sda_sync_q[1];
    ev.rise  = !scl_last_q && scl_sync_q[1];
    ev.fall  = scl_last_q && !scl_sync_q[1];
    ev.sda   = sda_sync_q[1];
  end

endmodule : mag_link

// ===== hdl/mag_pkg.sv
package mag_pkg;

  // Seven-bit bus address of the target.
  localparam logic [6:0] MAG_TARGET_ADDR = 7'h0d;

  // Register offsets.
  localparam logic [7:0] ADDR_X_LOW       = 8'h00;
  localparam logic [7:0] ADDR_X_HIGH      = 8'h01;
  localparam logic [7:0] ADDR_Y_LOW       = 8'h02;
  localparam logic [7:0] ADDR_Y_HIGH      = 8'h03;
  localparam logic [7:0] ADDR_Z_LOW       = 8'h04;
  localparam logic [7:0] ADDR_Z_HIGH      = 8'h05;
  localparam logic [7:0] ADDR_STATUS      = 8'h06;
  localparam logic [7:0] ADDR_TEMP_LOW    = 8'h07;
  localparam logic [7:0] ADDR_TEMP_HIGH   = 8'h08;
  localparam logic [7:0] ADDR_MEAS_CONFIG = 8'h09;
  localparam logic [7:0] ADDR_DEV_CONTROL = 8'h0a;
  localparam logic [7:0] ADDR_FLIP_PERIOD = 8'h0b;
  localparam logic [7:0] ADDR_RESERVED_C  = 8'h0c;
  localparam logic [7:0] ADDR_RESERVED_D  = 8'h0d;

  // Field positions in the device control register.
  localparam int CTL_SOFT_RESET_BIT = 7;
  localparam int CTL_WRAP_BIT       = 6;
  localparam int CTL_INT_DIS_BIT    = 0;

  // Operating modes.
  localparam logic [1:0] MODE_STANDBY    = 2'h0;
  localparam logic [1:0] MODE_CONTINUOUS = 2'h1;

  // Values after reset.
  localparam logic [7:0]  CONFIG_RESET      = 8'h00;
  localparam logic [7:0]  FLIP_PERIOD_RESET = 8'h00;
  localparam logic        WRAP_RESET        = 1'b0;
  localparam logic        INT_DIS_RESET     = 1'b0;
  localparam logic [15:0] AXIS_RESET        = 16'h0000;

  // Bit count of one byte on the bus.
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef struct packed {
    logic [15:0] x_axis_value;
    logic [15:0] y_axis_value;
    logic [15:0] z_axis_value;
    logic [15:0] temperature_value;
    logic        overflow_flag;
  } mag_sample_type;

  typedef struct packed {
    logic [1:0] oversample_ratio;
    logic [1:0] field_range;
    logic [1:0] output_rate;
    logic [1:0] mode;
  } mag_config_type;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic sda;
  } mag_bus_event_type;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_ADDR      = 4'h1,
    ST_ADDR_ACK  = 4'h2,
    ST_REG       = 4'h3,
    ST_REG_ACK   = 4'h4,
    ST_WDATA     = 4'h5,
    ST_WDATA_ACK = 4'h6,
    ST_RDATA     = 4'h7,
    ST_RACK      = 4'h8
  } mag_state_type;

endpackage : mag_pkg

// ===== hdl/mag_ptr.sv
// Next register pointer, with the optional roll within the output window.
module mag_ptr
  import mag_pkg::*;
(
  input  wire logic [7:0] ptr,      // Current pointer.
  input  wire logic       wrap,     // Roll-over active for this read.
  output logic      [7:0] ptr_next  // Pointer for the following byte.
);

  always_comb
  begin
    if (wrap && ptr == ADDR_STATUS)
    begin
      ptr_next = ADDR_X_LOW;
    end
    else
    begin
      ptr_next = ptr + 8'h01;
    end
  end

endmodule : mag_ptr

// ===== hdl/mag_top.sv
module mag_top
  import mag_pkg::*;
(
  input  wire logic           clk,            // Core clock, 200 MHz.
  input  wire logic           rst_b,          // Asynchronous reset, low.
  input  wire logic           scl_i,          // Bus clock pin.
  input  wire logic           sda_i,          // Bus data pin level.
  output logic                sda_o,          // Data pin drive value.
  output logic                sda_oe,         // Data pin pulled low.
  input  wire logic           sample_valid,   // New measurement, pulse.
  input  mag_sample_type      sample_in,      // Measurement values.
  output mag_config_type      config_out,     // Measurement settings.
  output logic [7:0]          flip_period,    // Set/reset period value.
  output logic                data_ready_pin, // Ready pulse on the pin.
  output logic                bus_busy        // Between start and stop.
);

  mag_bus_event_type ev;
  mag_state_type     state_q;
  mag_state_type     state_d;
  logic [3:0]        bit_q;
  logic [3:0]        bit_d;
  logic [7:0]        rx_q;
  logic [7:0]        rx_d;
  logic [7:0]        tx_q;
  logic [7:0]        tx_d;
  logic [7:0]        ptr_q;
  logic [7:0]        ptr_d;
  logic [7:0]        base_q;
  logic [7:0]        base_d;
  logic              wrap_q;
  logic              wrap_d;
  logic              controller_acknowledge_q;
  logic              controller_acknowledge_d;
  logic              oe_q;
  logic              oe_d;
  logic              busy_q;
  logic              busy_d;
  logic [7:0]        ptr_nx;
  logic [7:0]        rd_addr;
  logic [7:0]        rd_byte;
  logic              load_rd;
  logic              wr_en;

  mag_sample_type    sample_q;
  mag_sample_type    sample_d;
  logic              data_ready_flag_q;
  logic              data_ready_flag_d;
  logic              dor_q;
  logic              dor_d;
  mag_config_type    cfg_q;
  mag_config_type    cfg_d;
  logic              rol_q;
  logic              rol_d;
  logic              intdis_q;
  logic              intdis_d;
  logic [7:0]        fp_q;
  logic [7:0]        fp_d;
  logic              pin_q;
  logic              pin_d;
  logic              take;
  logic              rd_clear;

  mag_link u_link (
    .clk   (clk),
    .rst_b (rst_b),
    .scl_i (scl_i),
    .sda_i (sda_i),
    .ev    (ev)
  );

  mag_ptr u_ptr (
    .ptr      (ptr_q),
    .wrap     (wrap_q),
    .ptr_next (ptr_nx)
  );

  // The first byte of a read comes from the stored base address.
  assign rd_addr = (state_q == ST_ADDR_ACK) ? base_q : ptr_nx;

  always_comb
  begin
    unique case (rd_addr)
      ADDR_X_LOW:       rd_byte = sample_q.x_axis_value[7:0];
      ADDR_X_HIGH:      rd_byte = sample_q.x_axis_value[15:8];
      ADDR_Y_LOW:       rd_byte = sample_q.y_axis_value[7:0];
      ADDR_Y_HIGH:      rd_byte = sample_q.y_axis_value[15:8];
      ADDR_Z_LOW:       rd_byte = sample_q.z_axis_value[7:0];
      ADDR_Z_HIGH:      rd_byte = sample_q.z_axis_value[15:8];
      ADDR_STATUS:      rd_byte = {5'h00, dor_q, sample_q.overflow_flag,
                                   data_ready_flag_q};
      ADDR_TEMP_LOW:    rd_byte = sample_q.temperature_value[7:0];
      ADDR_TEMP_HIGH:   rd_byte = sample_q.temperature_value[15:8];
      ADDR_MEAS_CONFIG: rd_byte = cfg_q;
      ADDR_DEV_CONTROL: rd_byte = {1'b0, rol_q, 5'h00, intdis_q};
      ADDR_FLIP_PERIOD: rd_byte = fp_q;
      default:          rd_byte = 8'h00;
    endcase
  end

  // Bus protocol. Samples are taken as the clock rises and the data line
  // only changes after the clock has fallen.
  always_comb
  begin
    state_d = state_q;
    bit_d   = bit_q;
    rx_d    = rx_q;
    tx_d    = tx_q;
    ptr_d   = ptr_q;
    base_d  = base_q;
    wrap_d  = wrap_q;
    controller_acknowledge_d  = controller_acknowledge_q;
    oe_d    = oe_q;
    busy_d  = busy_q;
    load_rd = 1'b0;
    wr_en   = 1'b0;
    if (ev.stop)
    begin
      state_d = ST_IDLE;
      oe_d    = 1'b0;
      busy_d  = 1'b0;
    end
    else if (ev.start)
    begin
      state_d = ST_ADDR;
      bit_d   = 4'h0;
      oe_d    = 1'b0;
      busy_d  = 1'b1;
    end
    else if (ev.rise)
    begin
      if (state_q == ST_ADDR || state_q == ST_REG || state_q == ST_WDATA)
      begin
        rx_d  = {rx_q[6:0], ev.sda};
        bit_d = bit_q + 4'h1;
      end
      else if (state_q == ST_RDATA)
      begin
        bit_d = bit_q + 4'h1;
      end
      else if (state_q == ST_RACK)
      begin
        controller_acknowledge_d = !ev.sda;
      end
    end
    else if (ev.fall)
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          oe_d = 1'b0;
        end
        ST_ADDR:
        begin
          if (bit_q == BITS_PER_BYTE)
          begin
            if (rx_q[7:1] == MAG_TARGET_ADDR)
            begin
              oe_d    = 1'b1;
              state_d = ST_ADDR_ACK;
            end
            else
            begin
              state_d = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK:
        begin
          bit_d = 4'h0;
          if (rx_q[0])
          begin
            ptr_d   = base_q;
            wrap_d  = rol_q && (base_q <= ADDR_STATUS);
            load_rd = 1'b1;
            oe_d    = !rd_byte[7];
            tx_d    = {rd_byte[6:0], 1'b0};
            state_d = ST_RDATA;
          end
          else
          begin
            oe_d    = 1'b0;
            state_d = ST_REG;
          end
        end
        ST_REG:
        begin
          if (bit_q == BITS_PER_BYTE)
          begin
            base_d  = rx_q;
            ptr_d   = rx_q;
            oe_d    = 1'b1;
            state_d = ST_REG_ACK;
          end
        end
        ST_REG_ACK:
        begin
          oe_d    = 1'b0;
          bit_d   = 4'h0;
          state_d = ST_WDATA;
        end
        ST_WDATA:
        begin
          if (bit_q == BITS_PER_BYTE)
          begin
            wr_en   = 1'b1;
            oe_d    = 1'b1;
            state_d = ST_WDATA_ACK;
          end
        end
        ST_WDATA_ACK:
        begin
          oe_d    = 1'b0;
          bit_d   = 4'h0;
          ptr_d   = ptr_nx;
          state_d = ST_WDATA;
        end
        ST_RDATA:
        begin
          if (bit_q == BITS_PER_BYTE)
          begin
            oe_d    = 1'b0;
            controller_acknowledge_d  = 1'b0;
            state_d = ST_RACK;
          end
          else
          begin
            oe_d = !tx_q[7];
            tx_d = {tx_q[6:0], 1'b0};
          end
        end
        ST_RACK:
        begin
          bit_d = 4'h0;
          if (controller_acknowledge_q)
          begin
            ptr_d   = ptr_nx;
            load_rd = 1'b1;
            oe_d    = !rd_byte[7];
            tx_d    = {rd_byte[6:0], 1'b0};
            state_d = ST_RDATA;
          end
          else
          begin
            oe_d    = 1'b0;
            state_d = ST_IDLE;
          end
        end
        default:
        begin
          state_d = ST_IDLE;
          oe_d    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= ST_IDLE;
      bit_q   <= 4'h0;
      rx_q    <= 8'h00;
      tx_q    <= 8'h00;
      ptr_q   <= 8'h00;
      base_q  <= 8'h00;
      wrap_q  <= 1'b0;
      controller_acknowledge_q  <= 1'b0;
      oe_q    <= 1'b0;
      busy_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      bit_q   <= bit_d;
      rx_q    <= rx_d;
      tx_q    <= tx_d;
      ptr_q   <= ptr_d;
      base_q  <= base_d;
      wrap_q  <= wrap_d;
      controller_acknowledge_q  <= controller_acknowledge_d;
      oe_q    <= oe_d;
      busy_q  <= busy_d;
    end
  end

  // Register file. New results are only taken in continuous mode.
  assign take     = sample_valid && (cfg_q.mode == MODE_CONTINUOUS);
  assign rd_clear = load_rd && (rd_addr <= ADDR_Z_HIGH);

  always_comb
  begin
    sample_d = take ? sample_in : sample_q;
    // A result landing in the same cycle as a clearing read still counts.
    data_ready_flag_d   = take ? 1'b1 : (rd_clear ? 1'b0 : data_ready_flag_q);
    dor_d    = (take && data_ready_flag_q) ? 1'b1 : (rd_clear ? 1'b0 : dor_q);
    cfg_d    = cfg_q;
    rol_d    = rol_q;
    intdis_d = intdis_q;
    fp_d     = fp_q;
    pin_d    = take && !intdis_q;
    if (wr_en)
    begin
      unique case (ptr_q)
        ADDR_MEAS_CONFIG: cfg_d = rx_q;
        ADDR_FLIP_PERIOD: fp_d  = rx_q;
        ADDR_DEV_CONTROL:
        begin
          if (rx_q[CTL_SOFT_RESET_BIT])
          begin
            sample_d = '{AXIS_RESET, AXIS_RESET, AXIS_RESET, AXIS_RESET,
                         1'b0};
            data_ready_flag_d   = 1'b0;
            dor_d    = 1'b0;
            cfg_d    = CONFIG_RESET;
            rol_d    = WRAP_RESET;
            intdis_d = INT_DIS_RESET;
            fp_d     = FLIP_PERIOD_RESET;
            pin_d    = 1'b0;
          end
          else
          begin
            rol_d    = rx_q[CTL_WRAP_BIT];
            intdis_d = rx_q[CTL_INT_DIS_BIT];
          end
        end
        default:
        begin
          cfg_d = cfg_q;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sample_q <= '{AXIS_RESET, AXIS_RESET, AXIS_RESET, AXIS_RESET, 1'b0};
      data_ready_flag_q   <= 1'b0;
      dor_q    <= 1'b0;
      cfg_q    <= CONFIG_RESET;
      rol_q    <= WRAP_RESET;
      intdis_q <= INT_DIS_RESET;
      fp_q     <= FLIP_PERIOD_RESET;
      pin_q    <= 1'b0;
    end
    else
    begin
      sample_q <= sample_d;
      data_ready_flag_q   <= data_ready_flag_d;
      dor_q    <= dor_d;
      cfg_q    <= cfg_d;
      rol_q    <= rol_d;
      intdis_q <= intdis_d;
      fp_q     <= fp_d;
      pin_q    <= pin_d;
    end
  end

  // Open-drain data pin: only ever pulled low.
  assign sda_o          = 1'b0;
  assign sda_oe         = oe_q;
  assign config_out     = cfg_q;
  assign flip_period    = fp_q;
  assign data_ready_pin = pin_q;
  assign bus_busy       = busy_q;

endmodule : mag_top

// ===== tb/mag_ctl_model.sv
module mag_ctl_model
(
  input  wire logic lclk,   // Controller timing clock.
  input  wire logic sda,    // Resolved data line.
  output logic      scl,    // Bus clock, high when idle.
  output logic      sda_low // Controller pulls data low.
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task tick(input int n);
    repeat (n) @(posedge lclk);
    #1;
  endtask : tick

  // Also serves as a repeated start when the clock is low.
  task start_c;
    sda_low = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(3);
    sda_low = 1'b1;
    tick(3);
    scl = 1'b0;
    tick(2);
  endtask : start_c

  task stop_c;
    sda_low = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(3);
    sda_low = 1'b0;
    tick(3);
  endtask : stop_c

  // Data moves two ticks after the clock falls so no false start is seen.
  task bit_c(input logic b, output logic s);
    sda_low = !b;
    tick(3);
    scl = 1'b1;
    tick(3);
    s = sda;
    scl = 1'b0;
    tick(2);
  endtask : bit_c

  task xfer(input logic [7:0] d, input logic ack_drv,
            output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_c(d[i], r[i]);
    bit_c(ack_drv, ack);
  endtask : xfer
endmodule : mag_ctl_model

// ===== tb/mag_top_bench.sv
module mag_top_bench
  import mag_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  logic           clk, lclk, rst_b, scl, ctl_low, sda_line;
  logic           sda_o, sda_oe, sample_valid, pin, busy, a, seen;
  logic [7:0]     flip, rb;
  mag_sample_type sample_in;
  mag_config_type cfg;
  int             fail_count, n_checks;

  // Open-drain line with a pull-up.
  assign sda_line = !(ctl_low || (sda_oe && !sda_o));

  mag_top DUT (.clk(clk), .rst_b(rst_b), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .sample_valid(sample_valid),
    .sample_in(sample_in), .config_out(cfg), .flip_period(flip),
    .data_ready_pin(pin), .bus_busy(busy));
  mag_ctl_model u_ctl (.lclk(lclk), .sda(sda_line), .scl(scl),
    .sda_low(ctl_low));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = !clk;
  end
  initial
  begin
    lclk = 1'b0;
    #1.3;
    forever #6 lclk = !lclk;
  end

  task check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task give_verdict;
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  task wr(input logic [7:0] ad, input logic [7:0] d);
    u_ctl.start_c();
    u_ctl.xfer({MAG_TARGET_ADDR, 1'b0}, 1'b1, rb, a);
    check("addr ack", 8'h00, {7'h00, a});
    u_ctl.xfer(ad, 1'b1, rb, a);
    check("reg ack", 8'h00, {7'h00, a});
    u_ctl.xfer(d, 1'b1, rb, a);
    check("data ack", 8'h00, {7'h00, a});
    u_ctl.stop_c();
  endtask : wr

  task rd_chk(input logic [7:0] ad, input logic [7:0] e [$]);
    u_ctl.start_c();
    u_ctl.xfer({MAG_TARGET_ADDR, 1'b0}, 1'b1, rb, a);
    u_ctl.xfer(ad, 1'b1, rb, a);
    u_ctl.start_c();
    u_ctl.xfer({MAG_TARGET_ADDR, 1'b1}, 1'b1, rb, a);
    check("read ack", 8'h00, {7'h00, a});
    foreach (e[i])
    begin
      u_ctl.xfer(8'hff, i == e.size() - 1, rb, a);
      check("read byte", e[i], rb);
    end
    u_ctl.stop_c();
    check("busy", 8'h00, {7'h00, busy});
  endtask : rd_chk

  task pulse(output logic s);
    s = 1'b0;
    @(posedge clk);
    #1 sample_valid = 1'b1;
    @(posedge clk);
    #1 sample_valid = 1'b0;
    repeat (3)
    begin
      s = s | (pin === 1'b1);
      @(posedge clk);
      #1;
    end
  endtask : pulse

  task t_reset;
    check("config", 8'h00, cfg);
    check("flip", 8'h00, flip);
    check("oe", 8'h00, {7'h00, sda_oe});
    rd_chk(ADDR_MEAS_CONFIG, '{8'h00, 8'h00, 8'h00});
  endtask : t_reset

  task t_write;
    wr(ADDR_MEAS_CONFIG, 8'h1d);
    check("config", 8'h1d, cfg);
    wr(ADDR_FLIP_PERIOD, 8'h01);
    check("flip", 8'h01, flip);
    rd_chk(ADDR_MEAS_CONFIG, '{8'h1d, 8'h00, 8'h01, 8'h00, 8'h00});
  endtask : t_write

  task t_refuse;
    wr(ADDR_X_LOW, 8'h55);
    wr(ADDR_DEV_CONTROL, 8'h3e);
    wr(ADDR_RESERVED_C, 8'ha5);
    rd_chk(ADDR_X_LOW, '{8'h00});
    rd_chk(ADDR_DEV_CONTROL, '{8'h00, 8'h01, 8'h00});
    u_ctl.start_c();
    u_ctl.xfer({MAG_TARGET_ADDR ^ 7'h01, 1'b0}, 1'b1, rb, a);
    check("other addr", 8'h01, {7'h00, a});
    u_ctl.stop_c();
  endtask : t_refuse

  task t_sample;
    pulse(seen);
    check("ready pin", 8'h01, {7'h00, seen});
    pulse(seen);
    rd_chk(ADDR_STATUS, '{8'h07});
    rd_chk(ADDR_X_LOW, '{8'h34, 8'h12, 8'h78, 8'h56,
                         8'hbc, 8'h9a, 8'h02, 8'hf0});
  endtask : t_sample

  task t_wrap;
    wr(ADDR_DEV_CONTROL, 8'h41);
    pulse(seen);
    check("pin off", 8'h00, {7'h00, seen});
    rd_chk(ADDR_Z_HIGH, '{8'h9a, 8'h02, 8'h34, 8'h12});
    rd_chk(ADDR_DEV_CONTROL, '{8'h41});
  endtask : t_wrap

  task t_soft;
    wr(ADDR_DEV_CONTROL, 8'h80);
    check("config", 8'h00, cfg);
    check("flip", 8'h00, flip);
    pulse(seen);
    check("standby pin", 8'h00, {7'h00, seen});
    rd_chk(ADDR_Z_HIGH, '{8'h00, 8'h00, 8'h00, 8'h00,
                          8'h00, 8'h00, 8'h00});
  endtask : t_soft

  initial
  begin
    rst_b = 1'b0;
    sample_valid = 1'b0;
    sample_in = {16'h1234, 16'h5678, 16'h9abc, 16'hdef0, 1'b1};
    fail_count = 0;
    n_checks = 0;
    repeat (6) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_write();
    t_refuse();
    t_sample();
    t_wrap();
    t_soft();
    give_verdict();
  end

  // Cuts a hung run short.
  initial
  begin
    repeat (90000) @(posedge clk);
    $display("Run exceeded its cycle limit");
    fail_count++;
    give_verdict();
  end
endmodule : mag_top_bench

// ===== tb/mag_top_checker.sv
module mag_top_checker
  import mag_pkg::*;
(
  input wire logic       clk,            // Core clock.
  input wire logic       rst_b,          // Reset, low.
  input wire logic       scl_i,          // Bus clock pin.
  input wire logic       sda_i,          // Bus data pin.
  input wire logic       sda_o,          // Data drive value.
  input wire logic       sda_oe,         // Data drive enable.
  input wire logic       sample_valid,   // New sample.
  input mag_config_type  config_out,     // Settings.
  input wire logic [7:0] flip_period,    // Period value.
  input wire logic       data_ready_pin, // Ready pulse.
  input wire logic       bus_busy        // Busy level.
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  property p_busy_start;
    scl_i && $past(scl_i) && $fell(sda_i) |-> ##[1:6] bus_busy;
  endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("busy missing after start");

  property p_busy_stop;
    scl_i && $past(scl_i) && $rose(sda_i) |-> ##[1:6] !bus_busy;
  endproperty
  a_busy_stop: assert property (p_busy_stop)
    else $error("busy stays after stop");

  property p_oe_idle;
    sda_oe |-> bus_busy;
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("data driven outside a transfer");

  // The data line may only move while the bus clock is low.
  property p_oe_scl_low;
    $changed(sda_oe) |-> !scl_i;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("data changed with clock high");

  property p_oe_hold;
    $rose(sda_oe) |-> sda_oe [*8];
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("driven low level too short");

  property p_drive_zero;
    sda_oe |-> !sda_o;
  endproperty
  a_drive_zero: assert property (p_drive_zero)
    else $error("drive value not low");

  property p_pin_pulse;
    data_ready_pin |=> !data_ready_pin;
  endproperty
  a_pin_pulse: assert property (p_pin_pulse)
    else $error("ready pin longer than a pulse");

  property p_pin_cause;
    data_ready_pin |-> $past(sample_valid) || $past(sample_valid, 2);
  endproperty
  a_pin_cause: assert property (p_pin_cause)
    else $error("ready pin without a sample");

  property p_standby;
    sample_valid && config_out.mode == MODE_STANDBY
      |=> !data_ready_pin ##1 !data_ready_pin;
  endproperty
  a_standby: assert property (p_standby)
    else $error("sample taken in standby");

  property p_cfg_bus;
    $changed(config_out) || $changed(flip_period) |-> bus_busy;
  endproperty
  a_cfg_bus: assert property (p_cfg_bus)
    else $error("settings changed outside a transfer");

  c_start: cover property ($rose(bus_busy));
  c_pin:   cover property (data_ready_pin);
  c_oe:    cover property ($rose(sda_oe));
endmodule : mag_top_checker

bind mag_top mag_top_checker u_chk (
  .clk(clk), .rst_b(rst_b), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .sample_valid(sample_valid),
  .config_out(config_out), .flip_period(flip_period),
  .data_ready_pin(data_ready_pin), .bus_busy(bus_busy)
);
